// ===== rtl/gpp_port.sv
// one general-purpose port: registers, pad control and input sampling
// How it works
// RULE1: three locations: output, direction, input sample
// RULE2: input sample read-only; others read and write
// RULE3: writing ones to input sample toggles output
// RULE4: global pull-up off kills every pull-up
// RULE5: direction one drives output value; zero inputs
// RULE6: pull-up only for input, one, not disabled
// RULE7: reset tri-states pads without needing clock
// RULE8: pad level always readable in input sample; in sleep the code reads zero on clamped pins, except interrupt pins
// RULE9: latch open on clock high, then flop
// RULE10: outside edge shows after half to 1.5 periods
// RULE11: own write shows one period later
// RULE12: tri-state to high passes pull-up or low
// RULE13: pull-up to low passes tri-state or high
// RULE14: masked writes change only addressed bits
// RULE15: each pin independent of its neighbours
// RULE16: strobes per port; clock, clamp, pull-off shared
// RULE17: pull-up off is control bit four
// RULE18: sleep clamps inputs except interrupt pins
// RULE19: all registers reset to zero
`timescale 1ns/1ps
`default_nettype none
module gpp_port #(
  parameter int WIDTH = gpp_pkg::GPP_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register strobes and data
  input wire gpp_pkg::gpp_wr_t wr,
  input wire gpp_pkg::gpp_rd_t rd,
  output logic [7:0] rd_data,
  // shared sleep clamp
  input wire logic sleep_clamp,
  input wire logic [WIDTH-1:0] ext_int_enable,
  // pads
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_n,
  output logic [WIDTH-1:0] pull_up_en,
  output logic global_pullup_off
);
  import gpp_pkg::*;

  gpp_state_t s_q;
  gpp_state_t s_d;
  logic [WIDTH-1:0] pin_clamped;
  logic [WIDTH-1:0] pin_latched;
  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] wdat;

  assign mask = wr.wr_mask[WIDTH-1:0];
  assign wdat = wr.wr_data[WIDTH-1:0];

  // deep-sleep clamp ahead of the input buffer
  assign pin_clamped = pad_in & ~({WIDTH{sleep_clamp}} & ~ext_int_enable); // RULE18

  gpp_sync_latch #(.WIDTH(WIDTH)) u_latch ( // RULE9
    .clk(clk),
    .d(pin_clamped),
    .q(pin_latched)
  );

  always_comb begin
    s_d = s_q;
    if (wr.out_write_strobe) begin
      s_d.output_value_reg[WIDTH-1:0] =
        (s_q.output_value_reg[WIDTH-1:0] & ~mask) | (wdat & mask); // RULE14
    end
    if (wr.toggle_write_strobe) begin
      s_d.output_value_reg[WIDTH-1:0] =
        s_d.output_value_reg[WIDTH-1:0] ^ (wdat & mask); // RULE3
    end
    if (wr.dir_write_strobe) begin
      s_d.direction_reg[WIDTH-1:0] =
        (s_q.direction_reg[WIDTH-1:0] & ~mask) | (wdat & mask); // RULE14
    end
    if (wr.ctrl_write_strobe && wr.wr_mask[GPP_PULLUP_OFF_BIT]) begin
      s_d.global_pullup_off = wr.wr_data[GPP_PULLUP_OFF_BIT]; // RULE17
    end
    // flop after the latch; samples pads in any direction
    s_d.input_sample_reg[WIDTH-1:0] = pin_latched; // RULE8 RULE9
    if (rst) begin
      s_d.output_value_reg = GPP_OUT_RESET; // RULE19
      s_d.direction_reg = GPP_DIR_RESET;
      s_d.input_sample_reg = GPP_SAMPLE_RESET;
      s_d.global_pullup_off = GPP_PULLUP_OFF_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // read mux; input sample is read-only storage
  always_comb begin
    rd_data = 8'h00;
    if (rd.out_read_strobe) begin
      rd_data = s_q.output_value_reg; // RULE1 RULE2
    end else if (rd.dir_read_strobe) begin
      rd_data = s_q.direction_reg;
    end else if (rd.input_read_strobe) begin
      rd_data = s_q.input_sample_reg;
    end else if (rd.ctrl_read_strobe) begin
      rd_data[GPP_PULLUP_OFF_BIT] = s_q.global_pullup_off;
    end
  end

  // per-pin pad control, no pin depends on another
  assign pad_out = s_q.output_value_reg[WIDTH-1:0]; // RULE5 RULE15
  // reset gates enable directly, no clock edge needed
  assign pad_oe_n = ~(s_q.direction_reg[WIDTH-1:0] & {WIDTH{~rst}}); // RULE7
  assign pull_up_en = ~s_q.direction_reg[WIDTH-1:0]
    & s_q.output_value_reg[WIDTH-1:0]
    & {WIDTH{~s_q.global_pullup_off & ~rst}}; // RULE4 RULE6
  assign global_pullup_off = s_q.global_pullup_off; // RULE16

  default clocking cb @(posedge clk); endclocking
  default disable iff (1'b0);

  a_reset_tristate: assert property (rst |-> (&pad_oe_n) && pull_up_en == '0) // RULE7
    else $error("pads not tri-stated in reset");
  a_reset_zero: assert property (rst |=> s_q.direction_reg == 8'h00 // RULE19
      && s_q.output_value_reg == 8'h00 && !global_pullup_off)
    else $error("registers not zero after reset");
  a_pullup_off_all: assert property (global_pullup_off |-> pull_up_en == '0) // RULE4
    else $error("pull-up on while globally disabled");
  a_drive_output: assert property (disable iff (rst)
      (pad_oe_n == ~s_q.direction_reg[WIDTH-1:0])
      && (pad_out == s_q.output_value_reg[WIDTH-1:0])) // RULE5
    else $error("pad drive does not follow direction and value");
  a_toggle_flip: assert property (disable iff (rst)
      wr.toggle_write_strobe && !wr.out_write_strobe ##1 !rst
      |-> s_q.output_value_reg[WIDTH-1:0] == ($past(s_q.output_value_reg[WIDTH-1:0])
        ^ $past(wdat & mask))) // RULE3
    else $error("toggle write did not invert output bits");
  a_dir_masked: assert property (disable iff (rst)
      wr.dir_write_strobe ##1 !rst
      |-> (s_q.direction_reg[WIDTH-1:0] & ~$past(mask))
        == ($past(s_q.direction_reg[WIDTH-1:0]) & ~$past(mask))) // RULE14
    else $error("direction write touched unaddressed bits");
  a_pullup_bit: assert property (disable iff (rst)
      wr.ctrl_write_strobe && wr.wr_mask[GPP_PULLUP_OFF_BIT] ##1 !rst
      |-> global_pullup_off == $past(wr.wr_data[GPP_PULLUP_OFF_BIT])) // RULE17
    else $error("pull-up off bit not written");
  a_read_input: assert property (rd.input_read_strobe && !rd.out_read_strobe
      && !rd.dir_read_strobe |-> rd_data == s_q.input_sample_reg) // RULE2
    else $error("input read returned wrong data");
  a_sleep_clamp: assert property ((pin_clamped
      & {WIDTH{sleep_clamp}} & ~ext_int_enable) == '0) // RULE18
    else $error("sleep clamp let input through");
  // pad steady over three edges: the latch saw the same level
  a_sample_lag: assert property (disable iff (rst) // RULE10 RULE11
      ($stable(pin_clamped) && !rst) [*3]
      |-> s_q.input_sample_reg[WIDTH-1:0] == $past(pin_clamped))
    else $error("steady pad not sampled within period");

  // write steps: strobe taken (control bit: not taken), then no reset on the next edge
  sequence s_out_write;
    wr.out_write_strobe && !wr.toggle_write_strobe ##1 !rst;
  endsequence

  sequence s_dir_write;
    wr.dir_write_strobe ##1 !rst;
  endsequence

  sequence s_no_ctrl_write;
    !(wr.ctrl_write_strobe && wr.wr_mask[GPP_PULLUP_OFF_BIT]) ##1 !rst;
  endsequence

  a_out_masked: assert property (disable iff (rst) // RULE14
      s_out_write |-> s_q.output_value_reg[WIDTH-1:0]
        == (($past(s_q.output_value_reg[WIDTH-1:0]) & ~$past(mask))
        | ($past(wdat) & $past(mask))))
    else $error("output write wrong or touched unaddressed bits");
  a_dir_value: assert property (disable iff (rst) // RULE14
      s_dir_write |-> (s_q.direction_reg[WIDTH-1:0] & $past(mask))
        == ($past(wdat) & $past(mask)))
    else $error("direction write did not land");
  a_pud_hold: assert property (disable iff (rst) // RULE17
      s_no_ctrl_write |-> global_pullup_off == $past(global_pullup_off))
    else $error("pull-up off bit changed without a write");

  // pull-up table for every pin outside reset
  a_pullup_table: assert property (disable iff (rst) // RULE6
      pull_up_en == (~s_q.direction_reg[WIDTH-1:0]
        & s_q.output_value_reg[WIDTH-1:0] & {WIDTH{~global_pullup_off}}))
    else $error("pull-up does not follow direction and value");

  // read mux, one strobe at a time by priority
  a_read_output: assert property (rd.out_read_strobe // RULE2
      |-> rd_data == s_q.output_value_reg)
    else $error("output read returned wrong data");
  a_read_dir: assert property (rd.dir_read_strobe && !rd.out_read_strobe // RULE2
      |-> rd_data == s_q.direction_reg)
    else $error("direction read returned wrong data");
  a_read_ctrl: assert property (rd == 4'h1 // RULE17
      |-> rd_data == {3'h0, global_pullup_off, 4'h0})
    else $error("control read returned wrong data");
  a_read_idle: assert property (rd == 4'h0 |-> rd_data == 8'h00) // RULE2
    else $error("read data not zero without a strobe");

  // input sample storage: reset, then only the latch feeds it
  a_sample_reset: assert property (rst |=> s_q.input_sample_reg == 8'h00) // RULE19
    else $error("input sample not zero after reset");
  a_sample_flop: assert property (!rst // RULE2 RULE9
      |=> s_q.input_sample_reg[WIDTH-1:0] == $past(pin_latched))
    else $error("input sample not loaded from latch");

  // awake, the pad passes the clamp untouched
  a_clamp_pass: assert property (!sleep_clamp |-> pin_clamped == pad_in) // RULE18
    else $error("input clamped while awake");
endmodule : gpp_port
`default_nettype wire

// ===== common/gpp_pkg.sv
// constants and carrier types for the general-purpose port
package gpp_pkg;
  localparam int GPP_WIDTH = 8;
  localparam int GPP_PULLUP_OFF_BIT = 4;
  localparam logic [7:0] GPP_OUT_RESET = 8'h00;
  localparam logic [7:0] GPP_DIR_RESET = 8'h00;
  localparam logic [7:0] GPP_SAMPLE_RESET = 8'h00;
  localparam logic GPP_PULLUP_OFF_RESET = 1'b0;
  localparam int GPP_CLK_PERIOD_NS = 100;
  // software read-back lag in clock periods
  localparam int GPP_READBACK_LAG_PERIODS = 1;
  localparam int GPP_READBACK_LAG_CYC = GPP_READBACK_LAG_PERIODS;

  typedef struct packed {
    logic out_write_strobe;
    logic dir_write_strobe;
    logic toggle_write_strobe;
    logic ctrl_write_strobe;
    logic [7:0] wr_mask;
    logic [7:0] wr_data;
  } gpp_wr_t;

  typedef struct packed {
    logic out_read_strobe;
    logic dir_read_strobe;
    logic input_read_strobe;
    logic ctrl_read_strobe;
  } gpp_rd_t;

  typedef struct packed {
    logic [7:0] output_value_reg;
    logic [7:0] direction_reg;
    logic [7:0] input_sample_reg;
    logic global_pullup_off;
  } gpp_state_t;
endpackage : gpp_pkg

// ===== rtl/gpp_sync_latch.sv
// input latch, transparent while the clock is high
`timescale 1ns/1ps
`default_nettype none
module gpp_sync_latch #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic clk,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  always_latch begin
    if (clk) begin
      q <= d;
    end
  end
endmodule : gpp_sync_latch
`default_nettype wire

// ===== tb/gpp_pad_model.sv
// pad model: drivers, pull-ups and an outside source on each pin
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pull_up_en,
  // outside source
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic flt_q = 1'b0;
  // undriven pins wander every cycle
  always @(posedge clk) flt_q <= ~flt_q;
  assign pad_in = (~pad_oe_n & pad_out)
    | (pad_oe_n & ext_en & ext_val)
    | (pad_oe_n & ~ext_en & (pull_up_en | {8{flt_q}}));
endmodule : gpp_pad_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the general-purpose port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gpp_wr_t wr = '0;
  gpp_rd_t rd = '0;
  logic sleep_clamp = 1'b0;
  // pads held low from outside until the reset values are read
  logic [7:0] ext_int_enable = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
  logic [7:0] pad_in, rd_data, pad_out, pad_oe_n, pull_up_en;
  logic global_pullup_off;
  int n_fail = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  gpp_port i_gpp_port (.clk(clk), .rst(rst), .wr(wr), .rd(rd),
    .rd_data(rd_data), .sleep_clamp(sleep_clamp),
    .ext_int_enable(ext_int_enable), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
    .global_pullup_off(global_pullup_off));
  gpp_pad_model i_gpp_pad_model (.clk(clk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // strobes: out 8, dir 4, toggle (write) or input (read) 2, control 1
  task automatic wt(input logic [3:0] s, input logic [7:0] m,
    input logic [7:0] d);
    @(posedge clk);
    wr <= {s, m, d};
    @(posedge clk);
    wr <= '0;
  endtask : wt
  task automatic rc(input logic [3:0] s, input logic [7:0] e);
    @(posedge clk);
    rd <= s;
    @(negedge clk);
    chk(rd_data, e);
    @(posedge clk);
    rd <= '0;
  endtask : rc
  initial begin
    #10;
    chk(pad_oe_n, 8'hff);
    chk(pull_up_en, 8'h00);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(4'h8, 8'h00);
    rc(4'h4, 8'h00);
    rc(4'h2, 8'h00);
    ext_en <= 8'h00;
    wt(4'h8, 8'hff, 8'hff);
    wt(4'h4, 8'hff, 8'h0f);
    rc(4'h2, 8'hff);
    rc(4'h4, 8'h0f);
    @(negedge clk);
    chk(pad_oe_n, 8'hf0);
    chk(pull_up_en, 8'hf0);
    wt(4'h1, 8'hff, 8'hff);
    rc(4'h1, 8'h10);
    chk(pull_up_en, 8'h00);
    wt(4'h1, 8'hff, 8'h00);
    wt(4'h2, 8'hff, 8'h81);
    rc(4'h8, 8'h7e);
    wt(4'h8, 8'h02, 8'h00);
    wt(4'h4, 8'h10, 8'hff);
    rc(4'h8, 8'h7c);
    rc(4'h4, 8'h1f);
    chk(pad_out & ~pad_oe_n, 8'h1c);
    chk(pull_up_en, 8'h60);
    ext_en <= 8'he0;
    ext_val <= 8'he0;
    rc(4'h2, 8'hfc);
    @(posedge clk);
    ext_val <= 8'h00;
    rd <= 4'h2;
    @(negedge clk);
    chk(rd_data, 8'hfc);
    @(negedge clk);
    chk(rd_data, 8'h1c);
    @(posedge clk);
    rd <= '0;
    sleep_clamp <= 1'b1;
    ext_int_enable <= 8'h80;
    ext_val <= 8'he0;
    rc(4'h2, 8'h80);
    wt(4'h8, 8'h40, 8'h00);
    @(negedge clk);
    chk(pull_up_en, 8'h20);
    wt(4'h4, 8'h40, 8'hff);
    @(negedge clk);
    chk(pad_oe_n, 8'ha0);
    final_report;
  end
  initial begin
    #50000;
    n_fail++;
    final_report;
  end
endmodule : tb
`default_nettype wire
